/* File: include/qrtc_cfg.svh */
/*
 Constants for the reversal torque compensation block: register offsets,
 field positions, reset values and scaling shifts. Assumes nothing else.
*/
`ifndef QRTC_CFG_SVH
`define QRTC_CFG_SVH
`define QRTC_OFS_FUNC1    8'h00
`define QRTC_OFS_FUNC5    8'h04
`define QRTC_OFS_AMTPOS   8'h08
`define QRTC_OFS_AMTNEG   8'h0C
`define QRTC_OFS_TOF      8'h10
`define QRTC_OFS_FRIC     8'h14
`define QRTC_OFS_DISP     8'h18
`define QRTC_OFS_TIMING   8'h1C
`define QRTC_OFS_VISC     8'h20
`define QRTC_OFS_SPRING   8'h24
`define QRTC_OFS_PATHG    8'h28
`define QRTC_OFS_CTRL     8'h2C
`define QRTC_OFS_STATUS   8'h30
`define QRTC_F1_METH_HI   9
`define QRTC_F1_METH_LO   8
`define QRTC_F1_LEGACY    2'h2
`define QRTC_F5_SPEED     1
`define QRTC_F5_FINE      2
`define QRTC_DISP_INERT   15
`define QRTC_CTRL_CCW     0
`define QRTC_RST_WORD     16'h0000
`define QRTC_RST_BYTE     8'h00
`define QRTC_AMT_OFF      16'hFFFF
`define QRTC_PCT_SCALE    34'sh64
`define QRTC_VIS_SHIFT    8
`define QRTC_SPR_SHIFT    12
`define QRTC_PATH_SHIFT   8
`define QRTC_SAT_MAX      34'sh7FFF
`define QRTC_SAT_MIN      -34'sh8000
`define QRTC_RESP_OKAY    2'h0
`define QRTC_RESP_SLVERR  2'h2
`endif

/* File: include/qrtc_pkg.sv */
/*
 Types of the reversal torque compensation block.
 Assumes qrtc_cfg.svh is on the include path.
*/
package qrtc_pkg;
   typedef enum logic [1:0] {METH_NONE, METH_LEGACY, METH_SPEED} qrtc_method_e;

   typedef struct packed {
      logic        lastNeg;
      logic        seen;
      logic        revPulse;
      logic        revToPos;
   } qrtc_dir_s;

   typedef struct packed {
      logic        awHeld, wHeld, awReady, wReady, bValid, arReady, rValid;
      logic [7:0]  awAddr;
      logic [31:0] wData;
      logic [3:0]  wStrb;
      logic [1:0]  bResp, rResp;
      logic [31:0] rData;
      logic [15:0] func1, func5, amtPos, amtNeg, torque_offset_abbr, disp, timing, visc, spring, pathGain;
      logic [7:0]  fric, collFric;
      logic        ccw;
      logic [15:0] compTorque;
      logic        compValid, pullUpEn, pullUpDir, inertiaEn;
      qrtc_method_e method;
   } qrtc_state_s;
endpackage

/* File: rtl/qrtc_dir_detect.sv */
/*
 Feed direction reversal detector for one axis.
 Assumes the commanded velocity comes from logic on sys_clk, sampled at ctlTick.
*/
`timescale 1ns/100ps
module qrtc_dir_detect
   import qrtc_pkg::*;
(
   input  wire logic        sys_clk,  // control clock
   input  wire logic        rst_b,    // sync reset, low
   input  wire logic        ctlTick,  // control cycle enable
   input  wire logic [15:0] velCmd,   // signed commanded velocity
   output logic             revPulse, // one-cycle reversal event
   output logic             revToPos  // new direction is positive
);
   qrtc_dir_s st_r, st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.revPulse = 1'b0;
      // zero velocity keeps the last direction, so a stop is not a reversal
      if (ctlTick && velCmd != 16'h0000) begin
         st_nxt.seen    = 1'b1;
         st_nxt.lastNeg = velCmd[15];
         if (st_r.seen && st_r.lastNeg != velCmd[15]) begin
            st_nxt.revPulse = 1'b1;
            st_nxt.revToPos = ~velCmd[15];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign revPulse = st_r.revPulse;
   assign revToPos = st_r.revToPos;

   chk_flip_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
      ctlTick && st_r.seen && velCmd != 16'h0000 && velCmd[15] != st_r.lastNeg |=> revPulse)
      else $error("reversal not flagged");
endmodule

/* File: rtl/qrtc_top.sv */
/*
 Reversal (lost motion) torque compensation for one servo axis, with an
 AXI4-Lite register slave. Assumes velocity, following error and the
 control tick come from logic on sys_clk; outputs feed the current loop.
*/
// Chosen here: the AXI4-Lite slave port and the register addresses.
// Notes on behaviour
// - function word 1 bits 9:8 equal 10 select the legacy method
// - function word 5 bit 1 selects the speed-dependent method
// - negative amount zero: positive amount used for both directions
// - both nonzero: first amount positive, second negative, swappable
// - amount of -1 suppresses compensation for its direction
// - word 5 bit 2 set: amounts in 0.01 percent, up to 20000
// - torque offset sign gives pull-up direction, zero disables pull-up
// - torque offset is ignored under the speed-dependent method
// - path-tracking term acts only with the speed method, on following delay
// - CW/CCW setting swaps which amount applies at each quadrant point
// - inertia estimation needs offset, friction and display bit F set
// - friction torque is handed to collision detection
// - compensation is extra torque in stall units at direction reversal
// - speed method adds a spring term, zero disables it
// - word 5 bit 2 picks percent or 0.01 percent units
`timescale 1ns/100ps
`include "qrtc_cfg.svh"
module qrtc_top
   import qrtc_pkg::*;
(
   input  wire logic        sys_clk,       // 40 MHz control clock
   input  wire logic        rst_b,         // sync reset, low
   input  wire logic        ctlTick,       // control cycle enable
   input  wire logic [15:0] velCmd,        // signed commanded velocity
   input  wire logic [15:0] followErr,     // signed path following delay
   input  wire logic        s_axi_awvalid, // write address valid
   output logic             s_axi_awready, // write address ready
   input  wire logic [31:0] s_axi_awaddr,  // write address
   input  wire logic        s_axi_wvalid,  // write data valid
   output logic             s_axi_wready,  // write data ready
   input  wire logic [31:0] s_axi_wdata,   // write data
   input  wire logic [3:0]  s_axi_wstrb,   // byte enables
   output logic             s_axi_bvalid,  // write response valid
   input  wire logic        s_axi_bready,  // write response ready
   output logic [1:0]       s_axi_bresp,   // write response
   input  wire logic        s_axi_arvalid, // read address valid
   output logic             s_axi_arready, // read address ready
   input  wire logic [31:0] s_axi_araddr,  // read address
   output logic             s_axi_rvalid,  // read data valid
   input  wire logic        s_axi_rready,  // read data ready
   output logic [31:0]      s_axi_rdata,   // read data
   output logic [1:0]       s_axi_rresp,   // read response
   output logic [15:0]      compTorque,    // signed torque, 0.01 % stall
   output logic             compValid,     // pulse with new torque
   output logic             pullUpEn,      // vertical pull-up enabled
   output logic             pullUpDir,     // pull-up direction, 1 negative
   output logic             inertiaEn,     // inertia estimation run
   output logic [7:0]       collFric       // friction for collision detect
);
   qrtc_state_s st_r, st_nxt;
   logic               revPulse;
   logic               revToPos;
   logic               posSide;
   logic [15:0]        selAmt;
   logic [15:0]        absVel;
   logic [15:0]        absErr;
   logic [31:0]        viscP;
   logic [31:0]        sprP;
   logic [31:0]        pathP;
   logic signed [33:0] baseT;
   logic signed [33:0] magT;
   logic signed [33:0] rawT;
   logic signed [33:0] tofT;
   qrtc_method_e       methNow;

   qrtc_dir_detect uDir (
      .sys_clk  (sys_clk),
      .rst_b    (rst_b),
      .ctlTick  (ctlTick),
      .velCmd   (velCmd),
      .revPulse (revPulse),
      .revToPos (revToPos)
   );

   function automatic logic isMapped(input logic [7:0] a);
      isMapped = (a <= `QRTC_OFS_STATUS) && (a[1:0] == 2'h0);
   endfunction

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   // speed method wins when both are selected, the legacy one is obsolete
   always_comb begin
      if (st_r.func5[`QRTC_F5_SPEED])
         methNow = METH_SPEED;
      else if (st_r.func1[`QRTC_F1_METH_HI:`QRTC_F1_METH_LO] == `QRTC_F1_LEGACY)
         methNow = METH_LEGACY;
      else
         methNow = METH_NONE;
   end

   assign posSide = revToPos ^ st_r.ccw;
   assign selAmt  = (posSide || st_r.amtNeg == `QRTC_RST_WORD) ? st_r.amtPos : st_r.amtNeg;
   assign absVel  = velCmd[15] ? 16'(-velCmd) : velCmd;
   assign absErr  = followErr[15] ? 16'(-followErr) : followErr;
   assign viscP   = st_r.visc * absVel;
   assign sprP    = st_r.spring * absVel;
   assign pathP   = st_r.pathGain * absErr;

   // amounts in whole percent are brought to 0.01 % so one datapath serves both
   assign baseT = st_r.func5[`QRTC_F5_FINE] ? 34'($signed(selAmt))
                                            : 34'($signed(selAmt)) * `QRTC_PCT_SCALE;
   assign tofT  = 34'($signed(st_r.torque_offset_abbr)) * `QRTC_PCT_SCALE;

   always_comb begin
      magT = baseT;
      if (methNow == METH_SPEED) begin
         magT = baseT + $signed({2'b00, viscP >> `QRTC_VIS_SHIFT})
                      + $signed({2'b00, sprP >> `QRTC_SPR_SHIFT});
         magT = magT + $signed({2'b00, pathP >> `QRTC_PATH_SHIFT});
      end
   end

   always_comb begin
      rawT = posSide ? magT : -magT;
      if (methNow == METH_LEGACY)
         rawT = rawT + tofT;
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.compValid = 1'b0;
      st_nxt.method    = methNow;

      // write channel: address and data taken independently
      if (s_axi_awvalid && st_r.awReady) begin
         st_nxt.awHeld = 1'b1;
         st_nxt.awAddr = s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && st_r.wReady) begin
         st_nxt.wHeld = 1'b1;
         st_nxt.wData = s_axi_wdata;
         st_nxt.wStrb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
         st_nxt.bValid = 1'b0;
      if (st_r.awHeld && st_r.wHeld && !st_r.bValid) begin
         st_nxt.awHeld = 1'b0;
         st_nxt.wHeld  = 1'b0;
         st_nxt.bValid = 1'b1;
         st_nxt.bResp  = isMapped(st_r.awAddr) ? `QRTC_RESP_OKAY : `QRTC_RESP_SLVERR;
         case (st_r.awAddr)
            `QRTC_OFS_FUNC1:  st_nxt.func1    = merge16(st_r.func1, st_r.wData, st_r.wStrb);
            `QRTC_OFS_FUNC5:  st_nxt.func5    = merge16(st_r.func5, st_r.wData, st_r.wStrb);
            `QRTC_OFS_AMTPOS: st_nxt.amtPos   = merge16(st_r.amtPos, st_r.wData, st_r.wStrb);
            `QRTC_OFS_AMTNEG: st_nxt.amtNeg   = merge16(st_r.amtNeg, st_r.wData, st_r.wStrb);
            `QRTC_OFS_TOF:    st_nxt.torque_offset_abbr      = merge16(st_r.torque_offset_abbr, st_r.wData, st_r.wStrb);
            `QRTC_OFS_DISP:   st_nxt.disp     = merge16(st_r.disp, st_r.wData, st_r.wStrb);
            `QRTC_OFS_TIMING: st_nxt.timing   = merge16(st_r.timing, st_r.wData, st_r.wStrb);
            `QRTC_OFS_VISC:   st_nxt.visc     = merge16(st_r.visc, st_r.wData, st_r.wStrb);
            `QRTC_OFS_SPRING: st_nxt.spring   = merge16(st_r.spring, st_r.wData, st_r.wStrb);
            `QRTC_OFS_PATHG:  st_nxt.pathGain = merge16(st_r.pathGain, st_r.wData, st_r.wStrb);
            `QRTC_OFS_FRIC: begin
               if (st_r.wStrb[0])
                  st_nxt.fric = st_r.wData[7:0];
            end
            `QRTC_OFS_CTRL: begin
               if (st_r.wStrb[0])
                  st_nxt.ccw = st_r.wData[`QRTC_CTRL_CCW];
            end
            default: ;
         endcase
      end
      st_nxt.awReady = !st_nxt.awHeld && !st_nxt.bValid;
      st_nxt.wReady  = !st_nxt.wHeld && !st_nxt.bValid;

      // read channel: one cycle from address to data
      if (s_axi_rvalid && s_axi_rready)
         st_nxt.rValid = 1'b0;
      if (s_axi_arvalid && st_r.arReady) begin
         st_nxt.rValid = 1'b1;
         st_nxt.rResp  = isMapped(s_axi_araddr[7:0]) && s_axi_araddr[31:8] == 24'h000000
                         ? `QRTC_RESP_OKAY : `QRTC_RESP_SLVERR;
         case (s_axi_araddr[7:0])
            `QRTC_OFS_FUNC1:  st_nxt.rData = {16'h0000, st_r.func1};
            `QRTC_OFS_FUNC5:  st_nxt.rData = {16'h0000, st_r.func5};
            `QRTC_OFS_AMTPOS: st_nxt.rData = {16'h0000, st_r.amtPos};
            `QRTC_OFS_AMTNEG: st_nxt.rData = {16'h0000, st_r.amtNeg};
            `QRTC_OFS_TOF:    st_nxt.rData = {16'h0000, st_r.torque_offset_abbr};
            `QRTC_OFS_FRIC:   st_nxt.rData = {24'h000000, st_r.fric};
            `QRTC_OFS_DISP:   st_nxt.rData = {16'h0000, st_r.disp};
            `QRTC_OFS_TIMING: st_nxt.rData = {16'h0000, st_r.timing};
            `QRTC_OFS_VISC:   st_nxt.rData = {16'h0000, st_r.visc};
            `QRTC_OFS_SPRING: st_nxt.rData = {16'h0000, st_r.spring};
            `QRTC_OFS_PATHG:  st_nxt.rData = {16'h0000, st_r.pathGain};
            `QRTC_OFS_CTRL:   st_nxt.rData = {31'h00000000, st_r.ccw};
            `QRTC_OFS_STATUS: st_nxt.rData = {12'h000, st_r.inertiaEn, st_r.pullUpEn,
                                              st_r.method, st_r.compTorque};
            default:          st_nxt.rData = 32'h00000000;
         endcase
      end
      st_nxt.arReady = !st_nxt.rValid;

      // torque fires only on a reversal with a method selected
      if (revPulse && methNow != METH_NONE && selAmt != `QRTC_AMT_OFF) begin
         st_nxt.compValid = 1'b1;
         if (rawT > `QRTC_SAT_MAX)
            st_nxt.compTorque = 16'h7FFF;
         else if (rawT < `QRTC_SAT_MIN)
            st_nxt.compTorque = 16'h8000;
         else
            st_nxt.compTorque = rawT[15:0];
      end

      st_nxt.pullUpEn  = st_r.torque_offset_abbr != `QRTC_RST_WORD;
      st_nxt.pullUpDir = st_r.torque_offset_abbr[15];
      st_nxt.inertiaEn = st_r.torque_offset_abbr != `QRTC_RST_WORD && st_r.fric != `QRTC_RST_BYTE
                         && st_r.disp[`QRTC_DISP_INERT];
      st_nxt.collFric  = st_r.fric;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign s_axi_awready = st_r.awReady;
   assign s_axi_wready  = st_r.wReady;
   assign s_axi_bvalid  = st_r.bValid;
   assign s_axi_bresp   = st_r.bResp;
   assign s_axi_arready = st_r.arReady;
   assign s_axi_rvalid  = st_r.rValid;
   assign s_axi_rdata   = st_r.rData;
   assign s_axi_rresp   = st_r.rResp;
   assign compTorque    = st_r.compTorque;
   assign compValid     = st_r.compValid;
   assign pullUpEn      = st_r.pullUpEn;
   assign pullUpDir     = st_r.pullUpDir;
   assign inertiaEn     = st_r.inertiaEn;
   assign collFric      = st_r.collFric;

   chk_suppress_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
      revPulse && selAmt == `QRTC_AMT_OFF |=> !compValid)
      else $error("suppressed direction compensated");

   chk_no_method: assert property (@(posedge sys_clk) disable iff (!rst_b)
      revPulse && !st_r.func5[`QRTC_F5_SPEED] && st_r.func1[9:8] != 2'h2 |=> !compValid)
      else $error("compensation without method");

   chk_legacy_fires: assert property (@(posedge sys_clk) disable iff (!rst_b)
      revPulse && st_r.func1[9:8] == 2'h2 && selAmt != 16'hFFFF |=> compValid)
      else $error("legacy method did not fire");

   chk_neg_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
      st_r.amtNeg == 16'h0000 |-> selAmt == st_r.amtPos)
      else $error("zero negative amount not replaced");

   chk_dir_sign: assert property (@(posedge sys_clk) disable iff (!rst_b)
      revPulse && methNow == METH_SPEED && selAmt != 16'hFFFF && !selAmt[15] && selAmt != 16'h0000
      |=> compValid && compTorque[15] == !$past(posSide))
      else $error("torque sign wrong");

   chk_fine_unit: assert property (@(posedge sys_clk) disable iff (!rst_b)
      revPulse && methNow == METH_LEGACY && posSide && st_r.func5[2] && st_r.torque_offset_abbr == 16'h0000
      && selAmt < 16'h4E21 |=> compTorque == $past(selAmt))
      else $error("fine unit scaled");

   chk_tof_ignored: assert property (@(posedge sys_clk) disable iff (!rst_b)
      revPulse && methNow == METH_SPEED
      |-> rawT == (posSide ? magT : -magT))
      else $error("offset leaked into speed method");

   chk_pullup_track: assert property (@(posedge sys_clk) disable iff (!rst_b)
      ##1 pullUpEn == ($past(st_r.torque_offset_abbr) != 16'h0000) && pullUpDir == $past(st_r.torque_offset_abbr[15]))
      else $error("pull-up does not follow offset");

   chk_inertia_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
      inertiaEn |-> $past(st_r.fric) != 8'h00 && $past(st_r.disp[15]) && $past(st_r.torque_offset_abbr) != 16'h0000)
      else $error("inertia estimate without settings");

   chk_bresp_both: assert property (@(posedge sys_clk) disable iff (!rst_b)
      $rose(s_axi_bvalid) |-> $past(st_r.awHeld) && $past(st_r.wHeld))
      else $error("write answered early");
endmodule

/* File: verif/qrtc_ctrl_model.sv */
/*
 Controller-side model: AXI4-Lite master tasks and the commanded velocity
 with its control tick. Assumes one sys_clk shared with the block.
*/
`timescale 1ns/100ps
module qrtc_ctrl_model
   import qrtc_pkg::*;
(
   input  wire logic        sys_clk,       // control clock
   output logic             ctlTick,       // control cycle pulse
   output logic [15:0]      velCmd,        // commanded velocity
   output logic             s_axi_awvalid, // aw valid
   input  wire logic        s_axi_awready, // aw ready
   output logic [31:0]      s_axi_awaddr,  // aw address
   output logic             s_axi_wvalid,  // w valid
   input  wire logic        s_axi_wready,  // w ready
   output logic [31:0]      s_axi_wdata,   // w data
   output logic [3:0]       s_axi_wstrb,   // w strobes
   input  wire logic        s_axi_bvalid,  // b valid
   output logic             s_axi_bready,  // b ready
   input  wire logic [1:0]  s_axi_bresp,   // b response
   output logic             s_axi_arvalid, // ar valid
   input  wire logic        s_axi_arready, // ar ready
   output logic [31:0]      s_axi_araddr,  // ar address
   input  wire logic        s_axi_rvalid,  // r valid
   output logic             s_axi_rready,  // r ready
   input  wire logic [31:0] s_axi_rdata,   // r data
   input  wire logic [1:0]  s_axi_rresp    // r response
);
   initial begin
      {ctlTick, velCmd, s_axi_awvalid, s_axi_awaddr, s_axi_wvalid, s_axi_wdata} = '0;
      {s_axi_bready, s_axi_arvalid, s_axi_araddr, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
   end

   task automatic velStep(input logic [15:0] v);
      @(posedge sys_clk);
      velCmd  <= v;
      ctlTick <= 1'h1;
      @(posedge sys_clk);
      ctlTick <= 1'h0;
   endtask

   task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw;
      logic w;
      aw = 1'h0;
      w = 1'h0;
      @(posedge sys_clk);
      s_axi_awvalid <= 1'h1;
      s_axi_awaddr  <= {24'h000000, a};
      s_axi_wvalid  <= 1'h1;
      s_axi_wdata   <= d;
      s_axi_bready  <= 1'h1;
      while (!(aw && w)) begin
         @(posedge sys_clk);
         // released payload toggles so a stale value is never mistaken for live
         if (!aw && s_axi_awready === 1'h1) begin
            aw = 1'h1;
            s_axi_awvalid <= 1'h0;
            s_axi_awaddr  <= ~s_axi_awaddr;
         end
         if (!w && s_axi_wready === 1'h1) begin
            w = 1'h1;
            s_axi_wvalid <= 1'h0;
            s_axi_wdata  <= ~s_axi_wdata;
         end
      end
      while (s_axi_bvalid !== 1'h1) @(posedge sys_clk);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask

   task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge sys_clk);
      s_axi_arvalid <= 1'h1;
      s_axi_araddr  <= {24'h000000, a};
      s_axi_rready  <= 1'h1;
      do @(posedge sys_clk); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      s_axi_araddr  <= ~s_axi_araddr;
      while (s_axi_rvalid !== 1'h1) @(posedge sys_clk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask
endmodule

/* File: verif/qrtc_bench.sv */
/*
 Self-checking bench for the reversal torque compensation block.
 Assumes qrtc_top and the controller model; one 40 MHz clock.
*/
`timescale 1ns/100ps
`include "qrtc_cfg.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin errors++; \
   $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module qrtc_bench
   import qrtc_pkg::*;
;
   logic        sys_clk = 1'h0;
   logic        rst_b = 1'h0;
   logic [15:0] followErr = 16'h0000;
   logic        ctlTick, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [15:0] velCmd, compTorque;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        compValid, pullUpEn, pullUpDir, inertiaEn;
   logic [7:0]  collFric;
   int          errors = 0;
   int          checks = 0;

   always #12.5 sys_clk = ~sys_clk;

   qrtc_top u_dut (.sys_clk, .rst_b, .ctlTick, .velCmd, .followErr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
      .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
      .s_axi_rresp, .compTorque, .compValid, .pullUpEn, .pullUpDir, .inertiaEn, .collFric);

   qrtc_ctrl_model m (.sys_clk, .ctlTick, .velCmd, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `QRTC_RESP_OKAY);
      logic [1:0] r;
      m.axiWrite(a, d, r);
      `CHK(r, er)
      repeat (2) @(posedge sys_clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = `QRTC_RESP_OKAY);
      logic [31:0] d;
      logic [1:0]  r;
      m.axiRead(a, d, r);
      `CHK(d, ed)
      `CHK(r, er)
   endtask

   // one tick with new velocity; a pulse must land on the first edge after the tick is taken
   task automatic rev(input logic [15:0] v, input logic hit, input logic [15:0] expT);
      int at;
      at = 0;
      m.velStep(v);
      for (int i = 1; i <= 4; i++) begin
         @(posedge sys_clk);
         #1;
         if (compValid === 1'h1) begin
            at = at + i;
            `CHK(compTorque, expT)
         end
      end
      `CHK(at, hit ? 1 : 0)
   endtask

   task automatic regsTest;
      rd(`QRTC_OFS_STATUS, 32'h00000000);
      wr(`QRTC_OFS_AMTPOS, 32'h000000C8);
      rd(`QRTC_OFS_AMTPOS, 32'h000000C8);
      wr(`QRTC_OFS_TIMING, 32'h00000000);
      wr(8'h40, 32'h00001234, `QRTC_RESP_SLVERR);
      rd(8'h40, 32'h00000000, `QRTC_RESP_SLVERR);
      wr(8'h0A, 32'h00005678, `QRTC_RESP_SLVERR);
      rd(8'h0A, 32'h00000000, `QRTC_RESP_SLVERR);
      wr(`QRTC_OFS_FUNC1, 32'h00000200);
      rd(`QRTC_OFS_STATUS, 32'h00010000);
   endtask

   task automatic legacyTest;
      wr(`QRTC_OFS_AMTPOS, 32'h0000000A);
      rev(16'h0064, 1'h0, 16'h0000);
      rev(16'hFF9C, 1'h1, 16'hFC18);
      rev(16'hFFCE, 1'h0, 16'h0000);
      rev(16'h0064, 1'h1, 16'h03E8);
   endtask

   task automatic dirTest;
      wr(`QRTC_OFS_AMTNEG, 32'h00000014);
      rev(16'hFF9C, 1'h1, 16'hF830);
      wr(`QRTC_OFS_CTRL, 32'h00000001);
      rev(16'h0064, 1'h1, 16'hF830);
      wr(`QRTC_OFS_CTRL, 32'h00000000);
      wr(`QRTC_OFS_AMTNEG, 32'h0000FFFF);
      rev(16'hFF9C, 1'h0, 16'h0000);
      rev(16'h0064, 1'h1, 16'h03E8);
      wr(`QRTC_OFS_AMTNEG, 32'h00000000);
   endtask

   task automatic pullUpTest;
      wr(`QRTC_OFS_TOF, 32'h00000005);
      rev(16'hFF9C, 1'h1, 16'hFE0C);
      `CHK({pullUpEn, pullUpDir}, 2'h2)
      wr(`QRTC_OFS_TOF, 32'h0000FFFB);
      `CHK({pullUpEn, pullUpDir}, 2'h3)
      wr(`QRTC_OFS_TOF, 32'h00000000);
      `CHK(pullUpEn, 1'h0)
      wr(`QRTC_OFS_TOF, 32'h0000FFFB);
   endtask

   task automatic speedTest;
      wr(`QRTC_OFS_FUNC5, 32'h00000002);
      wr(`QRTC_OFS_VISC, 32'h000007D0);
      rev(16'h0064, 1'h1, 16'h06F5);
      wr(`QRTC_OFS_FUNC5, 32'h00000006);
      wr(`QRTC_OFS_AMTPOS, 32'h000004D2);
      wr(`QRTC_OFS_VISC, 32'h00000000);
      wr(`QRTC_OFS_SPRING, 32'h00001000);
      wr(`QRTC_OFS_PATHG, 32'h00000100);
      followErr <= 16'hFFCE;
      rev(16'hFF9C, 1'h1, 16'hFA98);
      wr(`QRTC_OFS_FUNC5, 32'h00000000);
      wr(`QRTC_OFS_AMTPOS, 32'h0000000A);
      rev(16'h0064, 1'h1, 16'h01F4);
      wr(`QRTC_OFS_FUNC5, 32'h00000004);
      wr(`QRTC_OFS_TOF, 32'h00000000);
      rev(16'hFF9C, 1'h1, 16'hFFF6);
      rev(16'h0064, 1'h1, 16'h000A);
      wr(`QRTC_OFS_TOF, 32'h0000FFFB);
      wr(`QRTC_OFS_FUNC1, 32'h00000000);
      rev(16'hFF9C, 1'h0, 16'h0000);
   endtask

   task automatic inertiaTest;
      wr(`QRTC_OFS_FRIC, 32'h0000000F);
      wr(`QRTC_OFS_DISP, 32'h00008000);
      `CHK(inertiaEn, 1'h1)
      `CHK(collFric, 8'h0F)
      wr(`QRTC_OFS_DISP, 32'h00000000);
      `CHK(inertiaEn, 1'h0)
   endtask

   task tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'h1;
      repeat (2) @(posedge sys_clk);
      regsTest;
      legacyTest;
      dirTest;
      pullUpTest;
      speedTest;
      inertiaTest;
      tally_and_finish;
   end

   // roughly twenty-five times the expected run
   initial begin
      repeat (8000) @(posedge sys_clk);
      errors++;
      tally_and_finish;
   end
endmodule
